/* File: hw/ata_burst_crc_check.sv */
// Host-side burst engine with per-burst CRC and command retry
//
// Summary of operation
// [RULE1] Read data captured on drive's own strobe
// [RULE2] CRC accumulated over every burst word
// [RULE3] Host sends its CRC at burst end
// [RULE4] Drive compares CRC, flags mismatch
// [RULE5] Drive-reported CRC error triggers command retry
// [RULE6] Slow and double-rate burst modes supported; double rate on writes only, reads capture on rising strobe_clk only
// [RULE7] Fast mode doubles data, same strobe rate
// [RULE8] Protocol works at slower programmed speeds
// [RULE9] CRC reseeded at every burst start
`timescale 1ns/1ps
`include "ata_crc_defs.svh"
module ata_burst_crc_check
   import ata_crc_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             rst_b,
   input  wire logic             strobe_clk,
   input  wire logic             burst_go,
   input  wire logic             burst_write,
   input  wire logic             burst_stop,
   input  wire logic             fast_mode,
   input  wire ata_crc_pkg::div_t speed_div,
   input  wire logic             wr_valid,
   input  wire ata_crc_pkg::word_t wr_data,
   output logic                  wr_ready,
   output ata_crc_pkg::word_t    rd_data,
   output logic                  rd_valid,
   input  wire ata_crc_pkg::word_t dd_in,
   output ata_crc_pkg::word_t    dd_out,
   output logic                  dd_oe,
   output logic                  host_strobe,
   output logic                  burst_busy,
   output logic                  crc_sent,
   input  wire logic             drive_crc_err,
   input  wire logic             cmd_done,
   output logic                  cmd_retry,
   output logic                  cmd_ok
);
   import ata_crc_pkg::*;

   word_if in_w ();
   word_if tx_w ();

   assign in_w.valid = wr_valid;
   assign in_w.data  = wr_data;
   assign wr_ready   = in_w.ready;

   two_entry_buf u_buf (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .in_w    (in_w),
      .out_w   (tx_w)
   );

   // Link domain: drive strobe clocks the read capture
   ptr_t  rbin_q, rbin_d, rgray_q, wgray_m_q, wgray_s_q;
   logic  lrst_m_q, lrst_b_q, rden_m_q, rden_q;
   ptr_t  wbin_q, wbin_d, wgray_q, rgray_m_q, rgray_l_q;
   word_t mem_q [1 << `FIFO_AW];
   logic  lfull, lpush;
   logic  rd_en_q, rd_en_d;

   assign lfull = (wgray_q == {~rgray_l_q[`FIFO_AW:`FIFO_AW-1], rgray_l_q[`FIFO_AW-2:0]});
   assign lpush = rden_q && !lfull;

   always_comb
   begin
      wbin_d = wbin_q;
      if (lpush)
         wbin_d = wbin_q + ptr_t'(1);
   end

   always_ff @(posedge strobe_clk)
   begin
      lrst_m_q <= rst_b;
      lrst_b_q <= lrst_m_q;
      if (lpush)
         mem_q[wbin_q[`FIFO_AW-1:0]] <= dd_in; // [RULE1]
      if (!lrst_b_q)
      begin
         rden_m_q  <= 1'b0;
         rden_q    <= 1'b0;
         wbin_q    <= '0;
         wgray_q   <= '0;
         rgray_m_q <= '0;
         rgray_l_q <= '0;
      end
      else
      begin
         rden_m_q  <= rd_en_q;
         rden_q    <= rden_m_q;
         wbin_q    <= wbin_d;
         wgray_q   <= bin2gray(wbin_d);
         rgray_m_q <= rgray_q;
         rgray_l_q <= rgray_m_q;
      end
   end

   // System domain: read pointer side of the crossing
   logic rempty, pop_rd;

   assign rempty = (rgray_q == wgray_s_q);

   // Burst control, CRC and host strobe
   state_e st_q, st_d;
   word_t  crc_q, crc_d, dd_out_q, dd_out_d, rd_data_q, rd_data_d;
   div_t   div_q, div_d, div_lim;
   logic   hs_q, hs_d, oe_q, oe_d, sent_q, sent_d, rdv_q, rdv_d;
   logic   tick, tx_beat, crc_beat;

   assign div_lim = (speed_div < `DIV_MIN) ? `DIV_MIN : speed_div; // [RULE8]
   assign tick    = (div_q >= div_lim - div_t'(1));
   // Slow mode moves a word on rising strobe only, fast mode on both edges
   assign tx_beat = tick && tx_w.valid && (fast_mode || !hs_q)
                    && (st_q == ST_WRITE || st_q == ST_DRAIN); // [RULE6] [RULE7]
   assign crc_beat = tick && (st_q == ST_SEND_CRC) && (fast_mode || !hs_q);
   assign tx_w.ready = tx_beat;
   assign pop_rd  = !rempty && (st_q == ST_READ || st_q == ST_DRAIN) && !burst_write;

   always_comb
   begin
      st_d      = st_q;
      crc_d     = crc_q;
      dd_out_d  = dd_out_q;
      div_d     = tick ? div_t'(0) : div_q + div_t'(1);
      hs_d      = hs_q;
      oe_d      = oe_q;
      sent_d    = 1'b0;
      rdv_d     = 1'b0;
      rd_data_d = rd_data_q;
      rbin_d    = rbin_q;
      rd_en_d   = rd_en_q;
      if (st_q == ST_IDLE)
         div_d = div_t'(0);
      // Idle slow-mode falling half of the strobe carries no word
      if (tick && hs_q && !fast_mode)
         hs_d = 1'b0;
      if (tx_beat)
      begin
         dd_out_d = tx_w.data;
         crc_d    = crc_step(crc_q, tx_w.data); // [RULE2]
         hs_d     = ~hs_q;
      end
      if (pop_rd)
      begin
         rd_data_d = mem_q[rbin_q[`FIFO_AW-1:0]];
         crc_d     = crc_step(crc_q, mem_q[rbin_q[`FIFO_AW-1:0]]); // [RULE2]
         rdv_d     = 1'b1;
         rbin_d    = rbin_q + ptr_t'(1);
      end
      unique case (st_q)
         ST_IDLE:
         begin
            oe_d = 1'b0;
            if (burst_go)
            begin
               crc_d   = `CRC_SEED; // [RULE9]
               oe_d    = burst_write;
               rd_en_d = !burst_write;
               st_d    = burst_write ? ST_WRITE : ST_READ;
            end
         end
         ST_WRITE, ST_READ:
            if (burst_stop)
            begin
               rd_en_d = 1'b0;
               st_d    = ST_DRAIN;
            end
         ST_DRAIN:
            // Every word already moved must enter the CRC before it is sent
            if (!tx_w.valid && (burst_write || (rempty && !pop_rd)))
               st_d = ST_SEND_CRC;
         ST_SEND_CRC:
         begin
            oe_d = 1'b1;
            if (crc_beat)
            begin
               dd_out_d = crc_q; // [RULE3]
               hs_d     = ~hs_q;
               sent_d   = 1'b1;
               st_d     = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         st_q      <= ST_IDLE;
         crc_q     <= `CRC_SEED;
         dd_out_q  <= '0;
         div_q     <= '0;
         hs_q      <= 1'b0;
         oe_q      <= 1'b0;
         sent_q    <= 1'b0;
         rdv_q     <= 1'b0;
         rd_data_q <= '0;
         rbin_q    <= '0;
         rgray_q   <= '0;
         wgray_m_q <= '0;
         wgray_s_q <= '0;
         rd_en_q   <= 1'b0;
      end
      else
      begin
         st_q      <= st_d;
         crc_q     <= crc_d;
         dd_out_q  <= dd_out_d;
         div_q     <= div_d;
         hs_q      <= hs_d;
         oe_q      <= oe_d;
         sent_q    <= sent_d;
         rdv_q     <= rdv_d;
         rd_data_q <= rd_data_d;
         rbin_q    <= rbin_d;
         rgray_q   <= bin2gray(rbin_d);
         wgray_m_q <= wgray_q;
         wgray_s_q <= wgray_m_q;
         rd_en_q   <= rd_en_d;
      end
   end

   // Command outcome: drive's error pin decides retry
   logic err_m_q, err_s_q, err_seen_q, err_seen_d, retry_q, retry_d, ok_q, ok_d;

   always_comb
   begin
      err_seen_d = err_seen_q;
      if (cmd_done)
         err_seen_d = 1'b0;
      if (err_s_q)
         err_seen_d = 1'b1; // [RULE4]
      retry_d = cmd_done && (err_seen_q || err_s_q); // [RULE5]
      ok_d    = cmd_done && !(err_seen_q || err_s_q);
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         err_m_q    <= 1'b0;
         err_s_q    <= 1'b0;
         err_seen_q <= 1'b0;
         retry_q    <= 1'b0;
         ok_q       <= 1'b0;
      end
      else
      begin
         err_m_q    <= drive_crc_err;
         err_s_q    <= err_m_q;
         err_seen_q <= err_seen_d;
         retry_q    <= retry_d;
         ok_q       <= ok_d;
      end
   end

   assign dd_out      = dd_out_q;
   assign dd_oe       = oe_q;
   assign host_strobe = hs_q;
   assign rd_data     = rd_data_q;
   assign rd_valid    = rdv_q;
   assign burst_busy  = (st_q != ST_IDLE);
   assign crc_sent    = sent_q;
   assign cmd_retry   = retry_q;
   assign cmd_ok      = ok_q;
endmodule : ata_burst_crc_check

/* File: hw/ata_crc_defs.svh */
// Constants for the burst CRC host logic
`ifndef ATA_CRC_DEFS_SVH
`define ATA_CRC_DEFS_SVH
`define WORD_W     16
`define CRC_SEED   16'h4ABA
`define CRC_POLY   16'h1021
`define FIFO_AW    3
`define DIV_W      4
`define DIV_MIN    4'h2
`endif

/* File: hw/ata_crc_pkg.sv */
// Types and shared functions for the burst CRC host logic
`include "ata_crc_defs.svh"
package ata_crc_pkg;
   typedef logic [`WORD_W-1:0]  word_t;
   typedef logic [`FIFO_AW:0]   ptr_t;
   typedef logic [`DIV_W-1:0]   div_t;
   typedef enum logic [2:0] {ST_IDLE, ST_WRITE, ST_READ, ST_DRAIN, ST_SEND_CRC} state_e;

   function automatic word_t crc_step(input word_t crc, input word_t data);
      word_t c;
      c = crc;
      for (int i = `WORD_W - 1; i >= 0; i--)
      begin
         if (c[`WORD_W-1] ^ data[i])
            c = {c[`WORD_W-2:0], 1'b0} ^ `CRC_POLY;
         else
            c = {c[`WORD_W-2:0], 1'b0};
      end
      return c;
   endfunction : crc_step

   function automatic ptr_t bin2gray(input ptr_t b);
      return b ^ (b >> 1);
   endfunction : bin2gray
endpackage : ata_crc_pkg

/* File: hw/two_entry_buf.sv */
// Two-entry valid/ready buffer for outgoing burst words
`timescale 1ns/1ps
module two_entry_buf
   import ata_crc_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst_b,
   word_if.snk       in_w,
   word_if.src       out_w
);
   word_t      mem_q [2];
   word_t      mem_d [2];
   logic       wp_q, wp_d, rp_q, rp_d;
   logic [1:0] cnt_q, cnt_d;
   logic       push, pop;

   assign in_w.ready  = (cnt_q != 2'h2);
   assign out_w.valid = (cnt_q != 2'h0);
   assign out_w.data  = mem_q[rp_q];
   assign push        = in_w.valid && in_w.ready;
   assign pop         = out_w.valid && out_w.ready;

   always_comb
   begin
      mem_d = mem_q;
      wp_d  = wp_q;
      rp_d  = rp_q;
      cnt_d = cnt_q;
      if (push)
      begin
         mem_d[wp_q] = in_w.data;
         wp_d        = ~wp_q;
      end
      if (pop)
         rp_d = ~rp_q;
      if (push && !pop)
         cnt_d = cnt_q + 2'h1;
      else if (pop && !push)
         cnt_d = cnt_q - 2'h1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         wp_q     <= 1'b0;
         rp_q     <= 1'b0;
         cnt_q    <= 2'h0;
      end
      else
      begin
         mem_q <= mem_d;
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end
endmodule : two_entry_buf

/* File: hw/word_if.sv */
// Valid/ready word carrier between the host modules
`timescale 1ns/1ps
interface word_if;
   import ata_crc_pkg::*;
   logic  valid;
   logic  ready;
   word_t data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : word_if

/* File: sim/ata_burst_crc_check_tb.sv */
// Bench for the burst CRC host logic against the drive model
`timescale 1ns/1ps
module ata_burst_crc_check_tb;
   import ata_crc_pkg::*;
   typedef struct {logic fast; div_t div; int n; logic bad; logic retry;} row_s;
   logic  sys_clk, rst_b, burst_go, burst_write, burst_stop, fast_mode, wr_valid;
   logic  cmd_done, gen, corrupt, wr_ready, rd_valid, dd_oe, host_strobe, err_seen;
   logic  burst_busy, crc_sent, cmd_retry, cmd_ok, strobe_clk, drive_crc_err;
   div_t  speed_div;
   word_t wr_data, rd_data, dd_in, dd_out, last_rd;
   int    words, crc_n, rd_n, fails, checks_done;
   // Divider 0 must act as 2; row three corrupts the compare
   row_s  rows [5] = '{'{0, 4'h2, 5, 0, 0}, '{1, 4'h0, 6, 0, 0}, '{0, 4'h9, 3, 1, 1},
                       '{1, 4'h5, 4, 0, 0}, '{0, 4'h3, 2, 0, 0}};
   ata_burst_crc_check ata_burst_crc_check_i (
      .sys_clk       (sys_clk),
      .rst_b         (rst_b),
      .strobe_clk    (strobe_clk),
      .burst_go      (burst_go),
      .burst_write   (burst_write),
      .burst_stop    (burst_stop),
      .fast_mode     (fast_mode),
      .speed_div     (speed_div),
      .wr_valid      (wr_valid),
      .wr_data       (wr_data),
      .wr_ready      (wr_ready),
      .rd_data       (rd_data),
      .rd_valid      (rd_valid),
      .dd_in         (dd_in),
      .dd_out        (dd_out),
      .dd_oe         (dd_oe),
      .host_strobe   (host_strobe),
      .burst_busy    (burst_busy),
      .crc_sent      (crc_sent),
      .drive_crc_err (drive_crc_err),
      .cmd_done      (cmd_done),
      .cmd_retry     (cmd_retry),
      .cmd_ok        (cmd_ok)
   );
   drive_model drive_model_i (
      .sys_clk       (sys_clk),
      .gen           (gen),
      .corrupt       (corrupt),
      .fast_mode     (fast_mode),
      .dd_out        (dd_out),
      .dd_oe         (dd_oe),
      .host_strobe   (host_strobe),
      .crc_sent      (crc_sent),
      .burst_busy    (burst_busy),
      .strobe_clk    (strobe_clk),
      .dd_in         (dd_in),
      .drive_crc_err (drive_crc_err),
      .words         (words)
   );
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic check(input word_t seen, input word_t exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic idle;
      int t = 0;
      while (burst_busy !== 1'b0 && t < 3000)
      begin
         @(negedge sys_clk);
         t++;
      end
      if (burst_busy !== 1'b0)
      begin
         fails++;
         end_of_test;
      end
      repeat (10) @(negedge sys_clk);
   endtask : idle
   task automatic cmd(input logic exp);
      cmd_done = 1'b1;
      @(negedge sys_clk);
      cmd_done = 1'b0;
      check(16'(cmd_retry), 16'(exp));
      check(16'(cmd_ok), 16'(!exp));
   endtask : cmd
   task automatic wr_burst(input row_s r);
      int k = 0;
      int t = 0;
      fast_mode   = r.fast;
      speed_div   = r.div;
      corrupt     = r.bad;
      burst_write = 1'b1;
      burst_go    = 1'b1;
      @(negedge sys_clk);
      burst_go = 1'b0;
      wr_valid = 1'b1;
      while (k < r.n && t < 400)
      begin
         wr_data = 16'hA500 + 16'(k);
         #1;
         if (wr_ready === 1'b1)
            k++;
         t++;
         @(negedge sys_clk);
      end
      wr_valid   = 1'b0;
      // Words never taken count as a hang
      if (k < r.n)
      begin
         fails++;
         end_of_test;
      end
      burst_stop = 1'b1;
      @(negedge sys_clk);
      burst_stop = 1'b0;
      idle;
   endtask : wr_burst
   always @(posedge sys_clk)
   begin
      if (drive_crc_err === 1'b1)
         err_seen <= 1'b1;
      if (crc_sent === 1'b1)
         crc_n <= crc_n + 1;
      if (rd_valid === 1'b1)
      begin
         if (rd_n > 0)
            check(rd_data, last_rd + 16'h0001);
         last_rd <= rd_data;
         rd_n    <= rd_n + 1;
      end
   end
   initial
   begin
      {burst_go, burst_write, burst_stop, fast_mode, wr_valid, cmd_done, corrupt} = 7'h00;
      {crc_n, rd_n, fails, checks_done} = 0;
      speed_div = 4'h2;
      wr_data   = 16'h0000;
      last_rd   = 16'h0000;
      err_seen  = 1'b0;
      rst_b     = 1'b0;
      gen       = 1'b1;
      repeat (2) @(negedge sys_clk);
      check(16'(wr_ready), 16'h0001);
      check(16'(burst_busy | dd_oe | crc_sent | cmd_retry), 16'h0000);
      rst_b = 1'b1;
      gen   = 1'b0;
      foreach (rows[i])
      begin
         err_seen = 1'b0;
         wr_burst(rows[i]);
         check(16'(words), 16'(rows[i].n));
         check(16'(crc_n), 16'(i + 1));
         check(16'(err_seen), 16'(rows[i].bad));
         cmd(rows[i].retry);
      end
      burst_write = 1'b0;
      burst_go    = 1'b1;
      @(negedge sys_clk);
      burst_go = 1'b0;
      repeat (3) @(negedge sys_clk);
      gen      = 1'b1;
      burst_go = 1'b1;
      #42 gen  = 1'b0;
      @(negedge sys_clk);
      burst_go = 1'b0;
      repeat (20) @(negedge sys_clk);
      burst_stop = 1'b1;
      @(negedge sys_clk);
      burst_stop = 1'b0;
      idle;
      check(16'(rd_n > 0), 16'h0001);
      check(16'(crc_n), 16'h0006);
      end_of_test;
   end
endmodule : ata_burst_crc_check_tb

/* File: sim/burst_crc_sva.sv */
// Port assertions for the burst CRC host logic
`timescale 1ns/1ps
module burst_crc_sva
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic burst_go,
   input wire logic burst_write,
   input wire logic burst_busy,
   input wire logic dd_oe,
   input wire logic host_strobe,
   input wire logic crc_sent,
   input wire logic drive_crc_err,
   input wire logic cmd_done,
   input wire logic cmd_retry,
   input wire logic cmd_ok
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   a_write_start: assert property
      (burst_go && !burst_busy && burst_write |=> dd_oe && burst_busy) else $error("no write");
   a_read_start: assert property
      (burst_go && !burst_busy && !burst_write |=> burst_busy && !dd_oe) else $error("no read");
   a_crc_pulse: assert property (crc_sent |=> !crc_sent) else $error("crc pulse");
   a_crc_end: assert property
      (crc_sent |-> dd_oe ##[0:1] !burst_busy) else $error("crc not last");
   a_crc_beat: assert property (crc_sent |-> $changed(host_strobe)) else $error("crc beat");
   a_strobe_pace: assert property
      (dd_oe && $changed(host_strobe) |=> $stable(host_strobe)) else $error("strobe pace");
   a_oe_in_burst: assert property
      (dd_oe |-> burst_busy || $past(burst_busy)) else $error("bus outside burst");
   a_one_answer: assert property (cmd_done |=> cmd_retry != cmd_ok) else $error("answer");
   a_no_answer: assert property
      (!cmd_done |=> !cmd_retry && !cmd_ok) else $error("stray answer");
   a_err_retry: assert property
      ($fell(drive_crc_err) ##[3:20] cmd_done |=> cmd_retry) else $error("no retry");
endmodule : burst_crc_sva

bind ata_burst_crc_check burst_crc_sva burst_crc_sva_i (
   .sys_clk       (sys_clk),
   .rst_b         (rst_b),
   .burst_go      (burst_go),
   .burst_write   (burst_write),
   .burst_busy    (burst_busy),
   .dd_oe         (dd_oe),
   .host_strobe   (host_strobe),
   .crc_sent      (crc_sent),
   .drive_crc_err (drive_crc_err),
   .cmd_done      (cmd_done),
   .cmd_retry     (cmd_retry),
   .cmd_ok        (cmd_ok)
);

/* File: sim/drive_model.sv */
// Drive model: read strobe and data, write CRC keeper and compare
`timescale 1ns/1ps
`include "ata_crc_defs.svh"
module drive_model
   import ata_crc_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic               gen,
   input  wire logic               corrupt,
   input  wire logic               fast_mode,
   input  wire ata_crc_pkg::word_t dd_out,
   input  wire logic               dd_oe,
   input  wire logic               host_strobe,
   input  wire logic               crc_sent,
   input  wire logic               burst_busy,
   output logic                    strobe_clk,
   output ata_crc_pkg::word_t      dd_in,
   output logic                    drive_crc_err,
   output int                      words
);
   word_t crc    = `CRC_SEED;
   word_t nxt    = 16'h1000;
   logic  hs_q   = 1'b0;
   logic  busy_q = 1'b0;
   int    err_n  = 0;
   int    n      = 0;
   function automatic word_t upd(input word_t c, input word_t d);
      for (int i = 15; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `CRC_POLY : 16'h0000);
      return c;
   endfunction : upd
   // Strobe stands low between frames
   initial
   begin
      strobe_clk = 1'b0;
      #1.7;
      forever #3 strobe_clk = gen & ~strobe_clk;
   end
   always @(negedge strobe_clk) nxt <= nxt + 16'h0001;
   // Released bus shows the inverted word, never a stale copy
   assign dd_in = gen ? nxt : ~nxt;
   assign drive_crc_err = err_n > 0;
   assign words = n;
   always @(posedge sys_clk)
   begin
      hs_q   <= host_strobe;
      busy_q <= burst_busy;
      if (err_n > 0)
         err_n <= err_n - 1;
      if (burst_busy && !busy_q)
      begin
         crc <= `CRC_SEED;
         n   <= 0;
      end
      else if (crc_sent && n > 0 && (dd_out ^ {15'h0, corrupt}) !== crc)
         err_n <= 4;
      else if (dd_oe && !crc_sent && host_strobe != hs_q && (fast_mode || host_strobe))
      begin
         crc <= upd(crc, dd_out);
         n   <= n + 1;
      end
   end
endmodule : drive_model
